// >>> rbst_defs.svh
// Timing, sizing and item numbering constants for remote binary signal transfer.
`ifndef RBST_DEFS_SVH
`define RBST_DEFS_SVH

// Item numbers of the first input or received output of each group.
`define RBST_ID_FAST_IN   3541
`define RBST_ID_FAST_OUT  3545
`define RBST_ID_BG_IN     3549
`define RBST_ID_BG_OUT    3573

// Number of peers at the far ends of the protected object.
`define RBST_NUM_PEER     2

// Clock period and the length of one timer tick.
`define RBST_CLK_PERIOD_NS 25
`define RBST_TICK_MS       1
`define RBST_NS_PER_MS     1000000

// Ticks a peer must stay active before it counts as available.
`define RBST_STABLE_MS    10

// Width of the reset delay setting, in bits; the setting counts ticks.
`define RBST_DELAY_W      16

// FIFO depth for background snapshots.
`define RBST_FIFO_DEPTH   32

`endif

// >>> rbst_pkg.sv
// Shared types for remote binary signal transfer.
`default_nettype none
package rbst_pkg;

    // Kind of frame carried on the link.
    typedef enum logic {
        RBST_KIND_FAST,
        RBST_KIND_BG
    } rbst_kind_t;

    // Progress of the reset delay after a link fault.
    typedef enum logic [1:0] {
        RBST_FLT_IDLE,
        RBST_FLT_WAIT,
        RBST_FLT_DONE
    } rbst_flt_t;

endpackage
`default_nettype wire

// >>> rbst_top.sv
// Remote binary signal transfer: input sampling, link framing and received outputs.
//
// Notes on behaviour
// - Carry up to 28 binary items to peers.
// - Four fast commands go first, minimal latency.
// - Twenty-four background items at lower priority.
// - Fast inputs 1-4 reach matching received outputs.
// - Background inputs reach same-index received outputs.
// - No configuration; only signal mapping matters.
// - Broadcast to all peers, even incomplete topology.
// - Logged-out device still sends and receives.
// - Peer available only while active and stable.
// - Link fault starts delay, then clears outputs.
// - Items numbered 3541, 3545, 3549, 3573 onward.
`timescale 1ns/1ps
`default_nettype none
`include "rbst_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// Snapshot FIFO between input sampling and the link transmitter.
module rbst_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = `RBST_FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    // Pointers wrap naturally, so DEPTH must be a power of two.
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   cnt;
    } rbst_fifo_st_t;

    rbst_fifo_st_t    s;
    rbst_fifo_st_t    next_s;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    // Full and empty come straight from the occupancy count.
    assign in_ready  = (s.cnt != (AW+1)'(DEPTH));
    assign out_valid = (s.cnt != '0);
    assign out_data  = mem[s.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer and count update; a push and a pop together keep the count.
    always_comb begin
        next_s = s;
        if (push) begin
            next_s.wr = s.wr + AW'(1);
        end
        if (pop) begin
            next_s.rd = s.rd + AW'(1);
        end
        if (push && !pop) begin
            next_s.cnt = s.cnt + (AW+1)'(1);
        end else if (pop && !push) begin
            next_s.cnt = s.cnt - (AW+1)'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Storage carries no reset; only the pointers and count say what is valid.
    always_ff @(posedge clk) begin
        if (push) begin
            mem[s.wr] <= in_data;
        end
    end
endmodule // rbst_fifo

////////////////////////////////////////////////////////////////////////////////
// Top of the block: samples the local items, frames them and holds what peers send.
module rbst_top #(
    parameter int NUM_PEER    = `RBST_NUM_PEER,
    parameter int STABLE_MS   = `RBST_STABLE_MS,
    parameter int FIFO_DEPTH  = `RBST_FIFO_DEPTH,
    parameter int TICK_CYCLES =
        (`RBST_TICK_MS * `RBST_NS_PER_MS) / `RBST_CLK_PERIOD_NS
) (
    input  wire logic                      clk,
    input  wire logic                      rstn,
    input  wire logic [3:0]                fast_cmd_in,
    input  wire logic [23:0]               bg_signal_in,
    input  wire logic [NUM_PEER-1:0]       peer_active,
    input  wire logic                      link_fault,
    input  wire logic [`RBST_DELAY_W-1:0]  link_fault_clear_delay,
    output logic                           link_tx_valid,
    input  wire logic                      link_tx_ready,
    output rbst_pkg::rbst_kind_t           link_tx_kind,
    output logic      [23:0]               link_tx_data,
    input  wire logic                      link_rx_valid,
    input  wire rbst_pkg::rbst_kind_t      link_rx_kind,
    input  wire logic [23:0]               link_rx_data,
    output logic      [3:0]                fast_cmd_received,
    output logic      [23:0]               bg_signal_received,
    output logic      [NUM_PEER-1:0]       dev_available
);
    // Group sizes follow from the item numbering.
    localparam int NF  = `RBST_ID_FAST_OUT - `RBST_ID_FAST_IN;
    localparam int NB  = `RBST_ID_BG_OUT - `RBST_ID_BG_IN;
    localparam int NIN = NF + NB;
    localparam int TW  = $clog2(TICK_CYCLES);
    localparam int SW  = $clog2(STABLE_MS + 1);

    typedef struct packed {
        logic [NIN-1:0]                sync1;
        logic [NIN-1:0]                sync2;
        logic [NIN-1:0]                last;
        logic                          fast_pend;
        logic                          bg_pend;
        logic                          tx_valid;
        rbst_pkg::rbst_kind_t          tx_kind;
        logic [NB-1:0]                 tx_data;
        logic [NF-1:0]                 fast_rx;
        logic [NB-1:0]                 bg_rx;
        logic [TW-1:0]                 tick_cnt;
        logic                          tick;
        rbst_pkg::rbst_flt_t           flt;
        logic [`RBST_DELAY_W-1:0]      flt_ms;
        logic [NUM_PEER-1:0][SW-1:0]   stab;
        logic [NUM_PEER-1:0]           avail;
    } rbst_st_t;

    rbst_st_t      s;
    rbst_st_t      next_s;
    logic          fifo_in_ready;
    logic          fifo_out_valid;
    logic          fifo_out_ready;
    logic [NB-1:0] fifo_out_data;
    logic          can_load;
    logic          fast_chg;
    logic          bg_chg;

    // Outputs are the registered state itself.
    assign link_tx_valid      = s.tx_valid;
    assign link_tx_kind       = s.tx_kind;
    assign link_tx_data       = s.tx_data;
    assign fast_cmd_received  = s.fast_rx;
    assign bg_signal_received = s.bg_rx;
    assign dev_available      = s.avail;

    // Change detection on the synchronised inputs against what was last queued.
    assign fast_chg = (s.sync2[NF-1:0] != s.last[NF-1:0]);
    assign bg_chg   = (s.sync2[NIN-1:NF] != s.last[NIN-1:NF]);
    assign can_load = !s.tx_valid || link_tx_ready;

    // Background is drained only when no fast command waits for the slot.
    assign fifo_out_ready = can_load && !s.fast_pend && !fast_chg;

    // Background snapshots wait here, so a backlog delays fast commands by no more than the frame already in the slot.
    rbst_fifo #(
        .WIDTH (NB),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rstn      (rstn),
        .in_valid  (s.bg_pend),
        .in_ready  (fifo_in_ready),
        .in_data   (s.last[NIN-1:NF]),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    always_comb begin
        next_s = s;

        // Pins come from outside the clock domain; two flops before any use.
        next_s.sync1 = {bg_signal_in, fast_cmd_in};
        next_s.sync2 = s.sync1;

        // Millisecond tick for the delay and stability timers.
        next_s.tick = 1'b0;
        if (s.tick_cnt == TW'(TICK_CYCLES - 1)) begin
            next_s.tick_cnt = '0;
            next_s.tick     = 1'b1;
        end else begin
            next_s.tick_cnt = s.tick_cnt + TW'(1);
        end

        // A fresh fast change is always seen; nothing is gated by topology
        // or logout state, and no setting enables transfer.
        if (fast_chg) begin
            next_s.last[NF-1:0] = s.sync2[NF-1:0];
        end
        if (bg_chg) begin
            next_s.last[NIN-1:NF] = s.sync2[NIN-1:NF];
        end

        // A queued snapshot clears on push; a new change re-arms it (set wins).
        next_s.bg_pend = (s.bg_pend && !fifo_in_ready) || bg_chg;

        // Transmit slot: fast commands pre-empt queued background words.
        next_s.fast_pend = s.fast_pend || fast_chg;
        if (can_load) begin
            if (s.fast_pend) begin
                next_s.tx_valid  = 1'b1;
                next_s.tx_kind   = rbst_pkg::RBST_KIND_FAST;
                next_s.tx_data   = {{(NB-NF){1'b0}}, s.last[NF-1:0]};
                next_s.fast_pend = fast_chg;
            end else if (fifo_out_ready && fifo_out_valid) begin
                next_s.tx_valid = 1'b1;
                next_s.tx_kind  = rbst_pkg::RBST_KIND_BG;
                next_s.tx_data  = fifo_out_data;
            end else begin
                next_s.tx_valid = 1'b0;
            end
        end

        // Received frames update only their own group; others hold.
        if (link_rx_valid) begin
            if (link_rx_kind == rbst_pkg::RBST_KIND_FAST) begin
                next_s.fast_rx = link_rx_data[NF-1:0];
            end else begin
                next_s.bg_rx = link_rx_data;
            end
        end

        // Reset delay after a link fault; a fault that heals early cancels it.
        case (s.flt)
            rbst_pkg::RBST_FLT_IDLE: begin
                if (link_fault) begin
                    next_s.flt    = rbst_pkg::RBST_FLT_WAIT;
                    next_s.flt_ms = '0;
                end
            end
            rbst_pkg::RBST_FLT_WAIT: begin
                if (!link_fault) begin
                    next_s.flt = rbst_pkg::RBST_FLT_IDLE;
                end else if (s.flt_ms >= link_fault_clear_delay) begin
                    next_s.flt     = rbst_pkg::RBST_FLT_DONE;
                    next_s.fast_rx = '0;
                    next_s.bg_rx   = '0;
                end else if (s.tick) begin
                    next_s.flt_ms = s.flt_ms + `RBST_DELAY_W'(1);
                end
            end
            rbst_pkg::RBST_FLT_DONE: begin
                if (!link_fault) begin
                    next_s.flt = rbst_pkg::RBST_FLT_IDLE;
                end
            end
            default: begin
                next_s.flt = rbst_pkg::RBST_FLT_IDLE;
            end
        endcase

        // A peer counts as available once active for STABLE_MS ticks running.
        for (int p = 0; p < NUM_PEER; p++) begin
            if (!peer_active[p]) begin
                next_s.stab[p]  = '0;
                next_s.avail[p] = 1'b0;
            end else begin
                if (s.tick && (s.stab[p] != SW'(STABLE_MS))) begin
                    next_s.stab[p] = s.stab[p] + SW'(1);
                end
                next_s.avail[p] = (s.stab[p] == SW'(STABLE_MS));
            end
        end
    end

    // All state is registered here; reset gives idle link and cleared outputs.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule // rbst_top

`default_nettype wire

// >>> rbst_props.sv
// Checker: port-level properties of the remote binary signal transfer block.
`timescale 1ns/1ps
`default_nettype none
`include "rbst_defs.svh"
module rbst_props #(
    parameter int NUM_PEER    = `RBST_NUM_PEER,
    parameter int STABLE_MS   = `RBST_STABLE_MS,
    parameter int TICK_CYCLES =
        (`RBST_TICK_MS * `RBST_NS_PER_MS) / `RBST_CLK_PERIOD_NS
) (
    input wire logic                     clk,
    input wire logic                     rstn,
    input wire logic [3:0]               fast_cmd_in,
    input wire logic [23:0]              bg_signal_in,
    input wire logic [NUM_PEER-1:0]      peer_active,
    input wire logic                     link_fault,
    input wire logic [`RBST_DELAY_W-1:0] link_fault_clear_delay,
    input wire logic                     link_tx_valid,
    input wire logic                     link_tx_ready,
    input wire rbst_pkg::rbst_kind_t     link_tx_kind,
    input wire logic [23:0]              link_tx_data,
    input wire logic                     link_rx_valid,
    input wire rbst_pkg::rbst_kind_t     link_rx_kind,
    input wire logic [23:0]              link_rx_data,
    input wire logic [3:0]               fast_cmd_received,
    input wire logic [23:0]              bg_signal_received,
    input wire logic [NUM_PEER-1:0]      dev_available
);
    int   act_cnt;
    int   flt_cnt;
    logic rxf;
    ////////////////////////////////////////////////////////////////////////////
    // Run lengths; a frame during a fault voids the clear check for that fault.
    always_ff @(posedge clk) begin
        act_cnt <= (!rstn || !peer_active[0]) ? 0 : act_cnt + 1;
        flt_cnt <= (!rstn || !link_fault) ? 0 : flt_cnt + 1;
        rxf     <= (!rstn || !link_fault) ? 1'b0 : (rxf || link_rx_valid);
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_fast_chg;
        link_tx_ready && (fast_cmd_in != $past(fast_cmd_in));
    endsequence
    a_fast_latency: assert property (s_fast_chg |-> ##[2:8]
        (link_tx_valid && link_tx_kind == rbst_pkg::RBST_KIND_FAST)) else $error("fast late");
    a_fast_pad: assert property (link_tx_valid && link_tx_kind == rbst_pkg::RBST_KIND_FAST
        |-> link_tx_data[23:4] == 20'h0) else $error("fast frame padding");
    a_tx_frame_hold: assert property (link_tx_valid && !link_tx_ready |=> link_tx_valid
        && $stable(link_tx_kind) && $stable(link_tx_data)) else $error("frame dropped");
    a_rx_fast_upd: assert property (link_rx_valid && !link_fault
        && link_rx_kind == rbst_pkg::RBST_KIND_FAST
        |=> fast_cmd_received == 4'($past(link_rx_data))) else $error("fast rx");
    a_rx_bg_upd: assert property (link_rx_valid && !link_fault
        && link_rx_kind == rbst_pkg::RBST_KIND_BG
        |=> bg_signal_received == $past(link_rx_data)) else $error("bg rx");
    a_rx_hold: assert property (!link_rx_valid && !link_fault && !$past(link_fault) |=>
        $stable(fast_cmd_received) && $stable(bg_signal_received)) else $error("rx moved");
    a_avail_drop: assert property (1'b1 |=>
        (dev_available & ~$past(peer_active)) == '0) else $error("avail kept");
    a_avail_rise: assert property ($rose(dev_available[0]) |->
        act_cnt >= (STABLE_MS - 1) * TICK_CYCLES) else $error("avail early");
    a_avail_late: assert property (act_cnt == (STABLE_MS + 1) * TICK_CYCLES + 3
        |-> dev_available[0]) else $error("avail late");
    a_fault_clear: assert property (!rxf && flt_cnt ==
        (int'(link_fault_clear_delay) + 1) * TICK_CYCLES + 3
        |-> fast_cmd_received == 4'h0 && bg_signal_received == 24'h0) else $error("no clear");
endmodule // rbst_props
bind rbst_top rbst_props #(
    .NUM_PEER    (NUM_PEER),
    .STABLE_MS   (STABLE_MS),
    .TICK_CYCLES (TICK_CYCLES)
) u_props (
    .clk                    (clk),
    .rstn                   (rstn),
    .fast_cmd_in            (fast_cmd_in),
    .bg_signal_in           (bg_signal_in),
    .peer_active            (peer_active),
    .link_fault             (link_fault),
    .link_fault_clear_delay (link_fault_clear_delay),
    .link_tx_valid          (link_tx_valid),
    .link_tx_ready          (link_tx_ready),
    .link_tx_kind           (link_tx_kind),
    .link_tx_data           (link_tx_data),
    .link_rx_valid          (link_rx_valid),
    .link_rx_kind           (link_rx_kind),
    .link_rx_data           (link_rx_data),
    .fast_cmd_received      (fast_cmd_received),
    .bg_signal_received     (bg_signal_received),
    .dev_available          (dev_available)
);
`default_nettype wire

// >>> rbst_peer.sv
// Peer model: far end of the link, takes frames with optional stall and sends frames.
`timescale 1ns/1ps
`default_nettype none
module rbst_peer (
    input wire logic             clk,
    input wire logic             stall,
    input wire logic             tx_valid,
    input wire rbst_pkg::rbst_kind_t tx_kind,
    input wire logic [23:0]      tx_data,
    output var logic             tx_ready,
    output var logic             rx_valid,
    output var rbst_pkg::rbst_kind_t rx_kind,
    output var logic [23:0]      rx_data
);
    rbst_pkg::rbst_kind_t lk;
    logic [23:0]          ld;
    int                   nf = 0;
    initial begin
        tx_ready = 1'h1;
        rx_valid = 1'h0;
        rx_kind = rbst_pkg::RBST_KIND_FAST;
        rx_data = 24'h0;
    end
    // Keep the last frame taken; ready only moves just after a rising edge.
    always @(posedge clk) begin
        tx_ready <= !stall;
        if (tx_valid && tx_ready) begin
            lk <= tx_kind;
            ld <= tx_data;
            nf <= nf + 1;
        end
    end
    // Frames carry no sender address, so picking senders is left to user logic.
    task automatic send(input rbst_pkg::rbst_kind_t k, input logic [23:0] d);
        @(negedge clk);
        rx_valid = 1'h1;
        rx_kind = k;
        rx_data = d;
        @(negedge clk);
        rx_valid = 1'h0;
        rx_data = ~d;
    endtask
endmodule // rbst_peer
`default_nettype wire

// >>> tb.sv
// Testbench for remote binary signal transfer.
`timescale 1ns/1ps
`default_nettype none
`include "rbst_defs.svh"
module tb;
    logic clk = 1'h0;
    logic rstn = 1'h0;
    logic flt = 1'h0;
    logic stall = 1'h0;
    logic [3:0] fin = 4'h0;
    logic [23:0] bin = 24'h0;
    logic [1:0] pact = 2'h0;
    logic [15:0] dly = 16'h3;
    logic txv, txr, rxv;
    rbst_pkg::rbst_kind_t txk, rxk;
    logic [23:0] txd, rxd, bsr;
    logic [3:0] fcr;
    logic [1:0] dav;
    int failures = 0;
    int total_checks = 0;
    int cyc = 0;
    rbst_top #(.STABLE_MS(2), .TICK_CYCLES(8)) u_dut (.clk(clk), .rstn(rstn),
        .fast_cmd_in(fin), .bg_signal_in(bin), .peer_active(pact), .link_fault(flt),
        .link_fault_clear_delay(dly), .link_tx_valid(txv), .link_tx_ready(txr),
        .link_tx_kind(txk), .link_tx_data(txd), .link_rx_valid(rxv), .link_rx_kind(rxk),
        .link_rx_data(rxd), .fast_cmd_received(fcr), .bg_signal_received(bsr),
        .dev_available(dav));
    rbst_peer u_peer (.clk(clk), .stall(stall), .tx_valid(txv), .tx_kind(txk),
        .tx_data(txd), .tx_ready(txr), .rx_valid(rxv), .rx_kind(rxk), .rx_data(rxd));
    always #12.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // A hung handshake must not stall the run forever.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            give_verdict();
        end
    end
    task automatic chk(string nm, logic [23:0] e, logic [23:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic w(int n);
        repeat (n) @(negedge clk);
    endtask
    // Waits, bounded, for the peer to take one more frame.
    task automatic wfr();
        int n;
        n = u_peer.nf;
        repeat (40) if (u_peer.nf == n) @(negedge clk);
    endtask
    task automatic chkf(rbst_pkg::rbst_kind_t k, logic [23:0] d);
        wfr();
        chk("tx kind", 24'(k), 24'(u_peer.lk));
        chk("tx data", d, u_peer.ld);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Each fast input alone, while no peer is active yet.
    task automatic t_fast();
        for (int i = 0; i < 4; i++) begin
            fin = 4'h1 << i;
            chkf(rbst_pkg::RBST_KIND_FAST, {20'h0, fin});
        end
        fin = 4'h0;
        chkf(rbst_pkg::RBST_KIND_FAST, 24'h0);
        $display("t_fast done");
    endtask
    // Overfill the queue behind a stalled link; the fast command must go right after the frame already in the slot.
    task automatic t_prio();
        int n0;
        stall = 1'h1;
        for (int k = 1; k <= 40; k++) begin
            bin = 24'(k);
            w(2);
        end
        fin = 4'h8;
        w(8);
        stall = 1'h0;
        chkf(rbst_pkg::RBST_KIND_BG, 24'h1);
        chkf(rbst_pkg::RBST_KIND_FAST, 24'h8);
        // A full queue plus the one latest snapshot that waited; one extra wait shows no more.
        n0 = u_peer.nf;
        repeat (`RBST_FIFO_DEPTH + 2) wfr();
        chk("bg frames", 24'(`RBST_FIFO_DEPTH + 1), 24'(u_peer.nf - n0));
        chk("bg last", 24'h28, u_peer.ld);
        $display("t_prio done");
    endtask
    // Frames update only their own group and are then held.
    task automatic t_rx();
        u_peer.send(rbst_pkg::RBST_KIND_BG, 24'ha5a5a5);
        u_peer.send(rbst_pkg::RBST_KIND_FAST, 24'h6);
        w(10);
        chk("bg rx", 24'ha5a5a5, bsr);
        chk("fast rx", 24'h6, 24'(fcr));
        u_peer.send(rbst_pkg::RBST_KIND_FAST, 24'h9);
        w(1);
        chk("fast rx2", 24'h9, 24'(fcr));
        chk("bg held", 24'ha5a5a5, bsr);
        $display("t_rx done");
    endtask
    // A short fault cancels; a fault outlasting the three-tick delay holds early, clears after, then applies frames.
    task automatic t_fault();
        flt = 1'h1;
        w(4);
        flt = 1'h0;
        w(32);
        chk("cancel", 24'ha5a5a5, bsr);
        flt = 1'h1;
        w(12);
        chk("early", 24'ha5a5a5, bsr);
        w(28);
        chk("clr bg", 24'h0, bsr);
        chk("clr fast", 24'h0, 24'(fcr));
        u_peer.send(rbst_pkg::RBST_KIND_BG, 24'h123);
        w(40);
        chk("after clr", 24'h123, bsr);
        flt = 1'h0;
        $display("t_fault done");
    endtask
    task automatic t_avail();
        pact = 2'h3;
        w(6);
        chk("avail early", 24'h0, 24'(dav));
        w(24);
        chk("avail", 24'h3, 24'(dav));
        pact = 2'h2;
        w(2);
        chk("avail drop", 24'h2, 24'(dav));
        $display("t_avail done");
    endtask
    initial begin
        w(2);
        rstn = 1'h1;
        w(4);
        t_fast();
        t_prio();
        t_rx();
        t_fault();
        t_avail();
        give_verdict();
    end
endmodule // tb
`default_nettype wire
